/* File: rtl/event_flag_pkg.sv */
package event_flag_pkg;

    // =========================================================
    // Register map
    // =========================================================
    localparam logic [7:0] ADDR_CHAN_A_COMM_CODE = 8'h02;
    localparam logic [7:0] ADDR_CHAN_B_COMM_CODE = 8'h03;
    localparam logic [7:0] ADDR_LINK_EVENT_FLAGS = 8'h05;
    localparam logic [7:0] ADDR_POWER_COMMAND_EVENT_FLAGS = 8'h06;
    localparam logic [7:0] ADDR_RESISTIVE_MEASURE_FLAGS = 8'h07;
    localparam logic [7:0] ADDR_SERIAL_MODE_EVENT_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_LINK_EVENT_MASK = 8'h09;
    localparam logic [7:0] ADDR_POWER_COMMAND_EVENT_MASK = 8'h0a;
    localparam logic [7:0] ADDR_RESISTIVE_MEASURE_MASK = 8'h0b;
    localparam logic [7:0] ADDR_SERIAL_MODE_EVENT_MASK = 8'h0c;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [7:0] RST_LINK_EVENT_FLAGS = 8'h80;
    localparam logic [7:0] RST_POWER_COMMAND_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] RST_RESISTIVE_MEASURE_FLAGS = 8'h00;
    localparam logic [7:0] RST_SERIAL_MODE_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_COMM_CODE = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Implemented bits per register; the rest read as zero
    localparam logic [7:0] IMPL_LINK_EVENT = 8'hff;
    localparam logic [7:0] IMPL_POWER_COMMAND = 8'hff;
    localparam logic [7:0] IMPL_RESISTIVE_MEASURE = 8'h0f;
    localparam logic [7:0] IMPL_SERIAL_MODE = 8'h3f;

    // =========================================================
    // Field positions
    // =========================================================
    localparam int BIT_INTERFACE_READY = 7;
    localparam int BIT_CHAN_A_CONNECT = 6;
    localparam int BIT_CHAN_B_CONNECT = 5;
    localparam int BIT_CHAN_A_IDLE = 4;
    localparam int BIT_CHAN_B_IDLE = 3;
    localparam int BIT_WETNESS_DONE = 2;
    localparam int BIT_CHAN_B_WETNESS = 1;
    localparam int BIT_CHAN_A_WETNESS = 0;

    localparam int BIT_UNDERVOLTAGE_LOCKOUT = 7;
    localparam int BIT_CONVERTER_FAULT = 6;
    localparam int BIT_THERMAL_FAULT = 5;
    localparam int BIT_NEW_DATA = 4;
    localparam int BIT_CHAN_B_COMMAND_COMPLETE = 3;
    localparam int BIT_CHAN_A_COMMAND_COMPLETE = 2;
    localparam int BIT_CHAN_B_COMMAND_FAILURE = 1;
    localparam int BIT_CHAN_A_COMMAND_FAILURE = 0;

    localparam int BIT_WETNESS_VALID = 3;
    localparam int BIT_RES_ABORT = 2;
    localparam int BIT_RES_OPEN = 1;
    localparam int BIT_RES_GROUND = 0;

    localparam int BIT_CHAN_B_SERIAL_TIMEOUT = 5;
    localparam int BIT_CHAN_B_SERIAL_FAIL = 4;
    localparam int BIT_CHAN_B_SERIAL_TRANSITION = 3;
    localparam int BIT_CHAN_A_SERIAL_TIMEOUT = 2;
    localparam int BIT_CHAN_A_SERIAL_FAIL = 1;
    localparam int BIT_CHAN_A_SERIAL_TRANSITION = 0;

    // =========================================================
    // Watched status levels, index and reset value
    // =========================================================
    localparam int LVL_COUNT = 12;
    localparam int LVL_INTERFACE_READY = 0;
    localparam int LVL_CHAN_A_CONNECT = 1;
    localparam int LVL_CHAN_B_CONNECT = 2;
    localparam int LVL_CHAN_A_IDLE = 3;
    localparam int LVL_CHAN_B_IDLE = 4;
    localparam int LVL_CHAN_A_WETNESS = 5;
    localparam int LVL_CHAN_B_WETNESS = 6;
    localparam int LVL_UNDERVOLTAGE_LOCKOUT = 7;
    localparam int LVL_CONVERTER_FAULT = 8;
    localparam int LVL_THERMAL_FAULT = 9;
    localparam int LVL_CHAN_A_SERIAL_MODE = 10;
    localparam int LVL_CHAN_B_SERIAL_MODE = 11;
    localparam logic [11:0] RST_LEVELS = 12'h001;

endpackage

/* File: rtl/event_flag_bank.sv */
module event_flag_bank #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0,
    parameter logic [WIDTH-1:0] IMPL_BITS = '1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] set_evt,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] flag_ff
);

    // =========================================================
    // Sticky flags
    // =========================================================
    logic [WIDTH-1:0] nxt_flag;
    logic [WIDTH-1:0] keep_mask;

    // Writing zero clears a bit, writing one leaves it; a set wins
    always_comb begin
        keep_mask = wr_en ? wr_data : {WIDTH{1'b1}};
        nxt_flag = ((flag_ff & keep_mask) | set_evt) & IMPL_BITS; // R25
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_ff <= RESET_VALUE & IMPL_BITS;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

endmodule

/* File: rtl/event_flag_registers.sv */
// What this block does
// R1: Interface-ready flag bit 7 of first register resets to one, sets on ready change.
// R2: Channel A connect flag, first register bit 6, sets on any connect change.
// R3: Channel B connect flag, first register bit 5, sets on any connect change.
// R4: Channel A idle flag, first register bit 4, sets on idle change.
// R5: Channel B idle flag, first register bit 3, sets on idle change.
// R6: Wetness-done flag, first register bit 2, sets when a measurement finishes.
// R7: Channel B wetness flag, first register bit 1, sets on wetness change.
// R8: Channel A wetness flag, first register bit 0, sets on wetness change.
// R9: Second register bit 7 sets on undervoltage lockout change.
// R10: Second register bit 6 sets on converter fault change.
// R11: Second register bit 5 sets on thermal fault change.
// R12: New-data flag, second register bit 4, sets when fresh data is stored.
// R13: Command complete flags, bits 3 and 2, set on completion per channel.
// R14: Command failure flags, bits 1 and 0, set on error per channel.
// R15: Third register bit 3 sets on a valid wetness result.
// R16: Third register bit 2 sets on an abort resistive result.
// R17: Third register bit 1 sets on an open resistive result.
// R18: Third register bit 0 sets on a ground resistive result.
// R19: Fourth register bits 5 and 2 set on serial-mode timeout per channel.
// R20: Fourth register bits 4 and 1 set on serial-mode entry failure.
// R21: Fourth register bits 3 and 0 set on serial-mode entry or exit.
// R22: Each flag has a same-position mask bit; zero blocks, one passes.
// R23: Channel communication code is valid only after its complete or failure flag.
// R24: One registered interrupt output, high from the cycle after any flag and its mask are both set.
// R25: Flags stay set until the host writes zero to them.
module event_flag_registers (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    output logic irq_req,
    input wire logic interface_ready_state,
    input wire logic chan_a_connect_state,
    input wire logic chan_b_connect_state,
    input wire logic chan_a_idle_state,
    input wire logic chan_b_idle_state,
    input wire logic wetness_done_pulse,
    input wire logic chan_a_wetness_state,
    input wire logic chan_b_wetness_state,
    input wire logic undervoltage_lockout_state,
    input wire logic converter_fault_state,
    input wire logic thermal_fault_state,
    input wire logic new_data_pulse,
    input wire logic chan_a_command_complete,
    input wire logic chan_b_command_complete,
    input wire logic chan_a_command_failure,
    input wire logic chan_b_command_failure,
    input wire logic [7:0] chan_a_comm_code,
    input wire logic [7:0] chan_b_comm_code,
    input wire logic wetness_valid_pulse,
    input wire logic res_abort_pulse,
    input wire logic res_open_pulse,
    input wire logic res_ground_pulse,
    input wire logic chan_a_serial_timeout,
    input wire logic chan_b_serial_timeout,
    input wire logic chan_a_serial_fail,
    input wire logic chan_b_serial_fail,
    input wire logic chan_a_serial_mode_state,
    input wire logic chan_b_serial_mode_state
);

    // =========================================================
    // Declarations
    // =========================================================
    logic [event_flag_pkg::LVL_COUNT-1:0] level_now;
    logic [event_flag_pkg::LVL_COUNT-1:0] level_prev_ff;
    logic [event_flag_pkg::LVL_COUNT-1:0] level_change;

    logic [7:0] link_set;
    logic [7:0] power_set;
    logic [7:0] resist_set;
    logic [7:0] serial_set;

    logic link_wr;
    logic power_wr;
    logic resist_wr;
    logic serial_wr;

    logic [7:0] link_event_flags;
    logic [7:0] power_command_event_flags;
    logic [7:0] resistive_measure_flags;
    logic [7:0] serial_mode_event_flags;

    logic [7:0] link_mask_ff;
    logic [7:0] power_mask_ff;
    logic [7:0] resist_mask_ff;
    logic [7:0] serial_mask_ff;

    logic [7:0] chan_a_code_ff;
    logic [7:0] chan_b_code_ff;

    logic [7:0] nxt_rdata;
    logic nxt_irq;

    // Write strobe for one address
    function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target,
                                    input logic en);
        wr_hit = en && (addr == target);
    endfunction

    // =========================================================
    // Status change detection
    // =========================================================
    always_comb begin
        level_now = '0;
        level_now[event_flag_pkg::LVL_INTERFACE_READY] = interface_ready_state;
        level_now[event_flag_pkg::LVL_CHAN_A_CONNECT] = chan_a_connect_state;
        level_now[event_flag_pkg::LVL_CHAN_B_CONNECT] = chan_b_connect_state;
        level_now[event_flag_pkg::LVL_CHAN_A_IDLE] = chan_a_idle_state;
        level_now[event_flag_pkg::LVL_CHAN_B_IDLE] = chan_b_idle_state;
        level_now[event_flag_pkg::LVL_CHAN_A_WETNESS] = chan_a_wetness_state;
        level_now[event_flag_pkg::LVL_CHAN_B_WETNESS] = chan_b_wetness_state;
        level_now[event_flag_pkg::LVL_UNDERVOLTAGE_LOCKOUT] = undervoltage_lockout_state;
        level_now[event_flag_pkg::LVL_CONVERTER_FAULT] = converter_fault_state;
        level_now[event_flag_pkg::LVL_THERMAL_FAULT] = thermal_fault_state;
        level_now[event_flag_pkg::LVL_CHAN_A_SERIAL_MODE] = chan_a_serial_mode_state;
        level_now[event_flag_pkg::LVL_CHAN_B_SERIAL_MODE] = chan_b_serial_mode_state;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_prev_ff <= event_flag_pkg::RST_LEVELS;
        end else begin
            level_prev_ff <= level_now;
        end
    end

    // Either direction of a level counts as a change
    assign level_change = level_now ^ level_prev_ff;

    // =========================================================
    // Set vectors
    // =========================================================
    always_comb begin
        link_set = '0;
        link_set[event_flag_pkg::BIT_INTERFACE_READY] =
            level_change[event_flag_pkg::LVL_INTERFACE_READY]; // R1
        link_set[event_flag_pkg::BIT_CHAN_A_CONNECT] =
            level_change[event_flag_pkg::LVL_CHAN_A_CONNECT]; // R2
        link_set[event_flag_pkg::BIT_CHAN_B_CONNECT] =
            level_change[event_flag_pkg::LVL_CHAN_B_CONNECT]; // R3
        link_set[event_flag_pkg::BIT_CHAN_A_IDLE] =
            level_change[event_flag_pkg::LVL_CHAN_A_IDLE]; // R4
        link_set[event_flag_pkg::BIT_CHAN_B_IDLE] =
            level_change[event_flag_pkg::LVL_CHAN_B_IDLE]; // R5
        link_set[event_flag_pkg::BIT_WETNESS_DONE] = wetness_done_pulse; // R6
        link_set[event_flag_pkg::BIT_CHAN_B_WETNESS] =
            level_change[event_flag_pkg::LVL_CHAN_B_WETNESS]; // R7
        link_set[event_flag_pkg::BIT_CHAN_A_WETNESS] =
            level_change[event_flag_pkg::LVL_CHAN_A_WETNESS]; // R8
    end

    always_comb begin
        power_set = '0;
        power_set[event_flag_pkg::BIT_UNDERVOLTAGE_LOCKOUT] =
            level_change[event_flag_pkg::LVL_UNDERVOLTAGE_LOCKOUT]; // R9
        power_set[event_flag_pkg::BIT_CONVERTER_FAULT] =
            level_change[event_flag_pkg::LVL_CONVERTER_FAULT]; // R10
        power_set[event_flag_pkg::BIT_THERMAL_FAULT] =
            level_change[event_flag_pkg::LVL_THERMAL_FAULT]; // R11
        power_set[event_flag_pkg::BIT_NEW_DATA] = new_data_pulse; // R12
        power_set[event_flag_pkg::BIT_CHAN_B_COMMAND_COMPLETE] = chan_b_command_complete; // R13
        power_set[event_flag_pkg::BIT_CHAN_A_COMMAND_COMPLETE] = chan_a_command_complete; // R13
        power_set[event_flag_pkg::BIT_CHAN_B_COMMAND_FAILURE] = chan_b_command_failure; // R14
        power_set[event_flag_pkg::BIT_CHAN_A_COMMAND_FAILURE] = chan_a_command_failure; // R14
    end

    always_comb begin
        resist_set = '0;
        resist_set[event_flag_pkg::BIT_WETNESS_VALID] = wetness_valid_pulse; // R15
        resist_set[event_flag_pkg::BIT_RES_ABORT] = res_abort_pulse; // R16
        resist_set[event_flag_pkg::BIT_RES_OPEN] = res_open_pulse; // R17
        resist_set[event_flag_pkg::BIT_RES_GROUND] = res_ground_pulse; // R18
    end

    always_comb begin
        serial_set = '0;
        serial_set[event_flag_pkg::BIT_CHAN_B_SERIAL_TIMEOUT] = chan_b_serial_timeout; // R19
        serial_set[event_flag_pkg::BIT_CHAN_A_SERIAL_TIMEOUT] = chan_a_serial_timeout; // R19
        serial_set[event_flag_pkg::BIT_CHAN_B_SERIAL_FAIL] = chan_b_serial_fail; // R20
        serial_set[event_flag_pkg::BIT_CHAN_A_SERIAL_FAIL] = chan_a_serial_fail; // R20
        serial_set[event_flag_pkg::BIT_CHAN_B_SERIAL_TRANSITION] =
            level_change[event_flag_pkg::LVL_CHAN_B_SERIAL_MODE]; // R21
        serial_set[event_flag_pkg::BIT_CHAN_A_SERIAL_TRANSITION] =
            level_change[event_flag_pkg::LVL_CHAN_A_SERIAL_MODE]; // R21
    end

    // =========================================================
    // Flag registers
    // =========================================================
    assign link_wr = wr_hit(reg_addr, event_flag_pkg::ADDR_LINK_EVENT_FLAGS, reg_wr_en);
    assign power_wr = wr_hit(reg_addr, event_flag_pkg::ADDR_POWER_COMMAND_EVENT_FLAGS,
                             reg_wr_en);
    assign resist_wr = wr_hit(reg_addr, event_flag_pkg::ADDR_RESISTIVE_MEASURE_FLAGS,
                              reg_wr_en);
    assign serial_wr = wr_hit(reg_addr, event_flag_pkg::ADDR_SERIAL_MODE_EVENT_FLAGS,
                              reg_wr_en);

    event_flag_bank #(
        .WIDTH(8),
        .RESET_VALUE(event_flag_pkg::RST_LINK_EVENT_FLAGS),
        .IMPL_BITS(event_flag_pkg::IMPL_LINK_EVENT)
    ) u_link_event_flags (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .set_evt(link_set),
        .wr_en(link_wr),
        .wr_data(reg_wdata),
        .flag_ff(link_event_flags)
    );

    event_flag_bank #(
        .WIDTH(8),
        .RESET_VALUE(event_flag_pkg::RST_POWER_COMMAND_EVENT_FLAGS),
        .IMPL_BITS(event_flag_pkg::IMPL_POWER_COMMAND)
    ) u_power_command_event_flags (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .set_evt(power_set),
        .wr_en(power_wr),
        .wr_data(reg_wdata),
        .flag_ff(power_command_event_flags)
    );

    event_flag_bank #(
        .WIDTH(8),
        .RESET_VALUE(event_flag_pkg::RST_RESISTIVE_MEASURE_FLAGS),
        .IMPL_BITS(event_flag_pkg::IMPL_RESISTIVE_MEASURE)
    ) u_resistive_measure_flags (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .set_evt(resist_set),
        .wr_en(resist_wr),
        .wr_data(reg_wdata),
        .flag_ff(resistive_measure_flags)
    );

    event_flag_bank #(
        .WIDTH(8),
        .RESET_VALUE(event_flag_pkg::RST_SERIAL_MODE_EVENT_FLAGS),
        .IMPL_BITS(event_flag_pkg::IMPL_SERIAL_MODE)
    ) u_serial_mode_event_flags (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .set_evt(serial_set),
        .wr_en(serial_wr),
        .wr_data(reg_wdata),
        .flag_ff(serial_mode_event_flags)
    );

    // =========================================================
    // Mask registers
    // =========================================================
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_mask_ff <= event_flag_pkg::RST_MASK;
            power_mask_ff <= event_flag_pkg::RST_MASK;
            resist_mask_ff <= event_flag_pkg::RST_MASK;
            serial_mask_ff <= event_flag_pkg::RST_MASK;
        end else begin
            if (wr_hit(reg_addr, event_flag_pkg::ADDR_LINK_EVENT_MASK, reg_wr_en)) begin
                link_mask_ff <= reg_wdata & event_flag_pkg::IMPL_LINK_EVENT; // R22
            end
            if (wr_hit(reg_addr, event_flag_pkg::ADDR_POWER_COMMAND_EVENT_MASK,
                       reg_wr_en)) begin
                power_mask_ff <= reg_wdata & event_flag_pkg::IMPL_POWER_COMMAND; // R22
            end
            if (wr_hit(reg_addr, event_flag_pkg::ADDR_RESISTIVE_MEASURE_MASK,
                       reg_wr_en)) begin
                resist_mask_ff <= reg_wdata & event_flag_pkg::IMPL_RESISTIVE_MEASURE; // R22
            end
            if (wr_hit(reg_addr, event_flag_pkg::ADDR_SERIAL_MODE_EVENT_MASK,
                       reg_wr_en)) begin
                serial_mask_ff <= reg_wdata & event_flag_pkg::IMPL_SERIAL_MODE; // R22
            end
        end
    end

    // =========================================================
    // Communication codes
    // =========================================================
    // Captured with the flag; the code then holds until the channel's next complete or failure
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chan_a_code_ff <= event_flag_pkg::RST_COMM_CODE;
            chan_b_code_ff <= event_flag_pkg::RST_COMM_CODE;
        end else begin
            if (chan_a_command_complete || chan_a_command_failure) begin
                chan_a_code_ff <= chan_a_comm_code; // R23
            end
            if (chan_b_command_complete || chan_b_command_failure) begin
                chan_b_code_ff <= chan_b_comm_code; // R23
            end
        end
    end

    // =========================================================
    // Interrupt request
    // =========================================================
    assign nxt_irq = |(link_event_flags & link_mask_ff)
        || |(power_command_event_flags & power_mask_ff)
        || |(resistive_measure_flags & resist_mask_ff)
        || |(serial_mode_event_flags & serial_mask_ff); // R24

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= nxt_irq; // R24
        end
    end

    // =========================================================
    // Read port
    // =========================================================
    always_comb begin
        case (reg_addr)
            event_flag_pkg::ADDR_CHAN_A_COMM_CODE: nxt_rdata = chan_a_code_ff;
            event_flag_pkg::ADDR_CHAN_B_COMM_CODE: nxt_rdata = chan_b_code_ff;
            event_flag_pkg::ADDR_LINK_EVENT_FLAGS: nxt_rdata = link_event_flags;
            event_flag_pkg::ADDR_POWER_COMMAND_EVENT_FLAGS: nxt_rdata = power_command_event_flags;
            event_flag_pkg::ADDR_RESISTIVE_MEASURE_FLAGS: nxt_rdata = resistive_measure_flags;
            event_flag_pkg::ADDR_SERIAL_MODE_EVENT_FLAGS: nxt_rdata = serial_mode_event_flags;
            event_flag_pkg::ADDR_LINK_EVENT_MASK: nxt_rdata = link_mask_ff;
            event_flag_pkg::ADDR_POWER_COMMAND_EVENT_MASK: nxt_rdata = power_mask_ff;
            event_flag_pkg::ADDR_RESISTIVE_MEASURE_MASK: nxt_rdata = resist_mask_ff;
            event_flag_pkg::ADDR_SERIAL_MODE_EVENT_MASK: nxt_rdata = serial_mask_ff;
            default: nxt_rdata = event_flag_pkg::READ_UNMAPPED;
        endcase
    end

    // Read data holds until the next read
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= event_flag_pkg::READ_UNMAPPED;
        end else if (reg_rd_en) begin
            reg_rdata <= nxt_rdata;
        end
    end

endmodule

/* File: dv/event_flag_registers_sva.sv */
module event_flag_registers_sva (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rdata,
    input wire logic irq_req,
    input wire logic chan_a_connect_state,
    input wire logic chan_a_command_complete,
    input wire logic res_ground_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic mask_wr_ff;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Set once any mask byte gets a nonzero write
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_wr_ff <= 1'b0;
        end else if (reg_wr_en && reg_addr inside {[8'h09:8'h0c]} && |reg_wdata) begin
            mask_wr_ff <= 1'b1;
        end
    end
    a_unmapped_reads_zero: assert property (
        reg_rd_en && !(reg_addr inside {[8'h02:8'h0c]}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds_idle: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved without read");
    a_res_spare_zero: assert property (
        reg_rd_en && reg_addr == 8'h07 |=> reg_rdata[7:4] == 4'h0)
        else $error("spare bits of 0x07 not zero");
    a_serial_spare_zero: assert property (
        reg_rd_en && reg_addr == 8'h08 |=> reg_rdata[7:6] == 2'h0)
        else $error("spare bits of 0x08 not zero");
    a_cmd_done_sets: assert property (
        chan_a_command_complete ##1 (reg_rd_en && reg_addr == 8'h06) |=> reg_rdata[2])
        else $error("command complete flag not set");
    a_ground_sets: assert property (
        res_ground_pulse ##1 (reg_rd_en && reg_addr == 8'h07) |=> reg_rdata[0])
        else $error("ground result flag not set");
    a_connect_sets: assert property (
        $changed(chan_a_connect_state) ##1 (reg_rd_en && reg_addr == 8'h05) |=> reg_rdata[6])
        else $error("connect change flag not set");
    a_irq_needs_mask: assert property (!mask_wr_ff |-> !irq_req)
        else $error("interrupt with all masks clear");
endmodule

bind event_flag_registers event_flag_registers_sva chk_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .irq_req(irq_req),
    .chan_a_connect_state(chan_a_connect_state),
    .chan_a_command_complete(chan_a_command_complete), .res_ground_pulse(res_ground_pulse));

/* File: dv/host_model.sv */
module host_model (
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wdata,
    output logic reg_rd_en,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wdata = 8'h00;
        reg_rd_en = 1'b0;
    end
    // Called at a rising edge; zero bits clear flags
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr_en <= 1'b1;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        @(negedge core_clk);
        v = reg_rdata;
    endtask
endmodule

/* File: dv/event_flag_registers_bench.sv */
module event_flag_registers_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [25:0] LV_BITS = 26'h090e0fb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr_en, reg_rd_en, irq_req;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [7:0] cd = 8'h00;
    logic [25:0] st = 26'h0000080;
    logic [7:0] sh [16];
    logic [31:0] rng_state = 32'h0000326f;
    int err_total = 0;
    int comparisons = 0;
    always #10 core_clk = ~core_clk;
    host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata));
    event_flag_registers DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
        .reg_rdata(reg_rdata), .irq_req(irq_req), .interface_ready_state(st[7]),
        .chan_a_connect_state(st[6]), .chan_b_connect_state(st[5]),
        .chan_a_idle_state(st[4]), .chan_b_idle_state(st[3]), .wetness_done_pulse(st[2]),
        .chan_b_wetness_state(st[1]), .chan_a_wetness_state(st[0]),
        .undervoltage_lockout_state(st[15]), .converter_fault_state(st[14]),
        .thermal_fault_state(st[13]), .new_data_pulse(st[12]),
        .chan_b_command_complete(st[11]), .chan_a_command_complete(st[10]),
        .chan_b_command_failure(st[9]), .chan_a_command_failure(st[8]),
        .chan_a_comm_code(cd), .chan_b_comm_code(cd), .wetness_valid_pulse(st[19]),
        .res_abort_pulse(st[18]), .res_open_pulse(st[17]), .res_ground_pulse(st[16]),
        .chan_b_serial_timeout(st[25]), .chan_b_serial_fail(st[24]),
        .chan_b_serial_mode_state(st[23]), .chan_a_serial_timeout(st[22]),
        .chan_a_serial_fail(st[21]), .chan_a_serial_mode_state(st[20]));
    function automatic logic [31:0] rnd();
        rng_state ^= rng_state << 13;
        rng_state ^= rng_state >> 17;
        rng_state ^= rng_state << 5;
        return rng_state;
    endfunction
    function automatic logic irq_exp();
        return |((sh[5] & sh[9]) | (sh[6] & sh[10]) | (sh[7] & sh[11]) | (sh[8] & sh[12]));
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        comparisons++;
        if (got !== want) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic bwr(input logic [7:0] a, input logic [7:0] w);
        @(posedge core_clk);
        host.wr(a, w);
        if (a inside {[8'h05:8'h08]}) sh[a[3:0]] &= w;
        if (a inside {[8'h09:8'h0c]})
            sh[a[3:0]] = w & (a[0] ? (a[1] ? 8'h0f : 8'hff) : a[1] ? 8'hff : 8'h3f);
        @(posedge core_clk);
        @(negedge core_clk);
        chk({7'h00, irq_req}, {7'h00, irq_exp()});
    endtask
    // Level bits of r toggle, pulse bits fire one cycle, then read at once
    task automatic ev(input logic [25:0] r, input logic [7:0] a);
        logic [7:0] c;
        c = 8'(rnd());
        @(posedge core_clk);
        st <= ((st ^ r) & LV_BITS) | (r & ~LV_BITS);
        cd <= c;
        @(posedge core_clk);
        st <= st & LV_BITS;
        sh[5] |= r[7:0];
        sh[6] |= r[15:8];
        sh[7] |= {4'h0, r[19:16]};
        sh[8] |= {2'h0, r[25:20]};
        if (r[10] || r[8]) sh[2] = c;
        if (r[11] || r[9]) sh[3] = c;
        host.rd(a, d);
        chk(d, sh[a[3:0]]);
        chk({7'h00, irq_req}, {7'h00, irq_exp()});
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        foreach (sh[i]) sh[i] = 8'h00;
        sh[5] = 8'h80;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 14; a++) begin
            @(posedge core_clk);
            host.rd(8'(a), d);
            chk(d, sh[a]);
        end
        bwr(8'h05, 8'h7f);
        bwr(8'h02, 8'hff);
        ev(26'h0000400, 8'h06);
        ev(26'h0000400, 8'h02);
        ev(26'h0000a00, 8'h03);
        ev(26'h0010000, 8'h07);
        ev(26'h0000040, 8'h05);
        for (int i = 0; i < 300; i++) begin
            ev(26'(rnd() & rnd()), 8'h05 + 8'(rnd() % 4));
            for (int a = 2; a < 13; a++) begin
                @(posedge core_clk);
                host.rd(8'(a), d);
                chk(d, sh[a]);
            end
            bwr(8'(2 + rnd() % 12), 8'(rnd()));
        end
        tally_and_finish();
    end
    initial begin
        #(60000 * 20);
        err_total++;
        tally_and_finish();
    end
endmodule
